// ### verilog/pwmtc_pkg.sv
// Package of constants and types for the PWM timer counter block
package pwmtc_pkg;
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
	localparam logic [1:0] DIR_UP = 2'h0;
	localparam logic [1:0] DIR_DOWN = 2'h1;
	localparam logic [1:0] DIR_UPDOWN = 2'h2;
	localparam logic [2:0] SRC_INTERNAL = 3'h0;
	localparam logic [2:0] SRC_EXT = 3'h1;
	localparam logic [2:0] SRC_EXT_INV = 3'h2;
	localparam logic [1:0] DUMMY_EDGES = 2'h2;
	typedef struct packed {
		logic channel_enable_bit;
		logic run;
		logic preset;
		logic [1:0] direction_mode_select;
		logic single_pass_select;
		logic [2:0] count_source_select;
	} pwmtc_ctrl_t;
	typedef struct packed {
		logic counter_running_status;
		logic count_up_status;
		logic limit_update_pending;
	} pwmtc_stat_t;
endpackage

// ### verilog/pwmtc_counter.sv
// Counter block of one 16-bit PWM timer channel
// Summary of operation
// - External input counts rising edges; inverted source counts falling edges.
// - Interrupt flags clear on write of 1; clear before enabling.
// - Mode select 0 gives comparator, 1 gives capture, per circuit.
// - One 16-bit counter counting up or down per count clock cycle.
// - Two-bit direction plus single-pass bit give six counting modes.
// - Run starts counting; repeat runs until cleared, one-shot stops itself.
// - Limit register bounds the counter to 0x0000 up to limit.
// - Limit may change while running in repeat; pending flag is reported.
// - Preset clears counter in up modes, loads limit in down mode.
// - Counter value readable at any time; software double-reads.
// - Busy status is 1 while running, 0 while idle.
// - Direction status is 1 counting up, 0 counting down.
// - Repeat up wraps past limit to zero; raised limit extends count.
// - Counting up, limit below count clears counter and counts to new limit.
// - One-shot up wraps past limit to zero and stops.
// - Repeat down reloads limit on underflow; new limit after underflow.
// - One-shot down reloads limit on underflow and stops.
// - Repeat up/down bounces zero to limit; limit change applies next up.
// - One-shot up/down stops on reaching zero going down.
`timescale 1ns/100ps
`default_nettype none
module pwmtc_counter #(
	parameter int NUM_CC = 2
) (
	input wire logic clock,
	input wire logic reset,
	input wire pwmtc_pkg::pwmtc_ctrl_t ctrl,
	input wire logic [15:0] max_count_limit,
	input wire logic limit_write,
	input wire logic count_tick,
	input wire logic external_count_input,
	input wire logic [NUM_CC-1:0] compare_or_capture_select,
	input wire logic [NUM_CC-1:0] irq_flag_set,
	input wire logic [NUM_CC-1:0] irq_flag_clear,
	output logic [15:0] counter_value,
	output pwmtc_pkg::pwmtc_stat_t status,
	output logic [NUM_CC-1:0] capture_mode,
	output logic [NUM_CC-1:0] irq_flag_register
);
	logic [15:0] cnt_q, cnt_d;
	logic [15:0] lim_q;
	logic [15:0] cnt_inc;
	logic [15:0] cnt_dec;
	logic up_q, up_d;
	logic busy_q, busy_d;
	logic pend_d;
	logic run_q;
	logic ext_q;
	logic [1:0] dummy_q;
	logic ext_level;
	logic ext_edge;
	logic dummy_done;
	logic step;
	logic active;
	logic is_ext;
	logic is_down;
	logic is_updown;
	logic is_up_phase;
	logic at_zero;
	logic at_limit;
	logic above_limit;
	logic run_start;
	logic [NUM_CC-1:0] flag_q;
	logic [NUM_CC-1:0] flag_d;

	// Inverted source flips the sensed edge
	assign ext_level = (ctrl.count_source_select == pwmtc_pkg::SRC_EXT_INV) ?
		~external_count_input : external_count_input;
	assign is_ext = (ctrl.count_source_select == pwmtc_pkg::SRC_EXT) ||
		(ctrl.count_source_select == pwmtc_pkg::SRC_EXT_INV);
	assign ext_edge = ext_level & ~ext_q;

	// Counting only while enabled, running and busy
	assign active = ctrl.channel_enable_bit & ctrl.run & busy_q;

	// Dummy edges are absorbed before the first real step
	assign dummy_done = dummy_q == pwmtc_pkg::DUMMY_EDGES;
	assign step = active & (is_ext ? (ext_edge & dummy_done) : count_tick);

	// Mode decode
	assign is_down = ctrl.direction_mode_select == pwmtc_pkg::DIR_DOWN;
	assign is_updown = ctrl.direction_mode_select == pwmtc_pkg::DIR_UPDOWN;
	assign is_up_phase = !is_down && up_q;

	// Count comparisons against zero and the live limit
	assign at_zero = cnt_q == 16'h0000;
	assign at_limit = cnt_q == lim_q;
	assign above_limit = cnt_q > lim_q;
	assign cnt_inc = cnt_q + 16'h0001;
	assign cnt_dec = cnt_q - 16'h0001;
	assign run_start = ctrl.run & ~run_q;

	// Limit write raises the pending flag
	assign pend_d = limit_write;

	always_comb begin
		cnt_d = cnt_q;
		up_d = up_q;
		busy_d = busy_q;
		if (ctrl.preset) begin
			cnt_d = is_down ? lim_q : 16'h0000;
			up_d = ~is_down;
		end else if (step) begin
			if (is_up_phase) begin
				// Up counting follows a live limit
				if (above_limit) begin
					cnt_d = 16'h0000;
				end else if (at_limit) begin
					if (is_updown) begin
						if (at_zero) begin
							// Zero limit: nothing to count down
							cnt_d = 16'h0000;
							if (ctrl.single_pass_select) begin
								busy_d = 1'b0;
							end
						end else begin
							cnt_d = cnt_dec;
							up_d = 1'b0;
						end
					end else begin
						cnt_d = 16'h0000;
						if (ctrl.single_pass_select) begin
							busy_d = 1'b0;
						end
					end
				end else begin
					cnt_d = cnt_inc;
				end
			end else if (is_down) begin
				if (at_zero) begin
					// Reload picks up a new limit only here
					cnt_d = lim_q;
					if (ctrl.single_pass_select) begin
						busy_d = 1'b0;
					end
				end else begin
					cnt_d = cnt_dec;
				end
			end else begin
				// Down pass of up/down mode
				if (at_zero) begin
					cnt_d = 16'h0000;
					up_d = 1'b1;
				end else begin
					cnt_d = cnt_dec;
					if (cnt_q == 16'h0001) begin
						up_d = 1'b1;
						if (ctrl.single_pass_select) begin
							busy_d = 1'b0;
						end
					end
				end
			end
		end
		if (run_start) begin
			busy_d = 1'b1;
		end
		if (!ctrl.run) begin
			busy_d = 1'b0;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cnt_q <= pwmtc_pkg::CNT_RESET;
			lim_q <= pwmtc_pkg::LIMIT_RESET;
			up_q <= 1'b1;
			busy_q <= 1'b0;
			run_q <= 1'b0;
			ext_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			lim_q <= limit_write ? max_count_limit : lim_q;
			up_q <= up_d;
			busy_q <= busy_d;
			run_q <= ctrl.run;
			ext_q <= ext_level;
		end
	end

	// Dummy edge counter restarts on each run
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			dummy_q <= 2'h0;
		end else if (run_start || !is_ext) begin
			dummy_q <= 2'h0;
		end else if (active && ext_edge && !dummy_done) begin
			dummy_q <= dummy_q + 2'h1;
		end
	end

	// Per-circuit flags, set wins over write-one-to-clear
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CC; gi++) begin : g_flag
			assign flag_d[gi] = (flag_q[gi] & ~irq_flag_clear[gi]) | irq_flag_set[gi];

			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					flag_q[gi] <= 1'b0;
				end else begin
					flag_q[gi] <= flag_d[gi];
				end
			end

			chk_flag_clear: assert property (@(posedge clock) disable iff (reset)
				irq_flag_clear[gi] && !irq_flag_set[gi] |=> !flag_q[gi])
				else $error("flag not cleared");
			chk_flag_set: assert property (@(posedge clock) disable iff (reset)
				irq_flag_set[gi] |=> irq_flag_register[gi])
				else $error("flag set lost");
		end
	endgenerate

	// Registered outputs
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			counter_value <= pwmtc_pkg::CNT_RESET;
			status <= '0;
			capture_mode <= '0;
			irq_flag_register <= '0;
		end else begin
			counter_value <= cnt_d;
			status.counter_running_status <= busy_d;
			status.count_up_status <= up_d;
			status.limit_update_pending <= pend_d;
			capture_mode <= compare_or_capture_select;
			irq_flag_register <= flag_d;
		end
	end

	chk_preset_up_zero: assert property (@(posedge clock) disable iff (reset)
		ctrl.preset && !is_down |=> counter_value == 16'h0000)
		else $error("preset did not clear counter");

	chk_preset_down_lim: assert property (@(posedge clock) disable iff (reset)
		ctrl.preset && is_down |=> counter_value == $past(lim_q))
		else $error("preset did not load limit");

	chk_hold_idle: assert property (@(posedge clock) disable iff (reset)
		!ctrl.channel_enable_bit && !ctrl.preset |=> $stable(cnt_q))
		else $error("counter moved while disabled");

	chk_hold_norun: assert property (@(posedge clock) disable iff (reset)
		!ctrl.run && !ctrl.preset |=> $stable(cnt_q))
		else $error("counter moved while stopped");

	chk_busy_run: assert property (@(posedge clock) disable iff (reset)
		!ctrl.run |=> !status.counter_running_status)
		else $error("busy set while run clear");

	chk_busy_start: assert property (@(posedge clock) disable iff (reset)
		run_start |=> status.counter_running_status)
		else $error("run did not start counter");

	chk_range_limit: assert property (@(posedge clock) disable iff (reset)
		step && !ctrl.preset && is_down && at_zero |=> cnt_q == $past(lim_q))
		else $error("down count did not reload");

	chk_up_wrap: assert property (@(posedge clock) disable iff (reset)
		step && !ctrl.preset && !is_down && !is_updown && up_q && cnt_q >= lim_q
		|=> cnt_q == 16'h0000)
		else $error("up count did not wrap");

	chk_up_clear: assert property (@(posedge clock) disable iff (reset)
		step && !ctrl.preset && is_up_phase && above_limit |=> cnt_q == 16'h0000)
		else $error("lowered limit did not clear");

	chk_up_step: assert property (@(posedge clock) disable iff (reset)
		step && !ctrl.preset && is_up_phase && !at_limit && !above_limit
		|=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("up step wrong");

	chk_down_step: assert property (@(posedge clock) disable iff (reset)
		step && !ctrl.preset && is_down && !at_zero
		|=> cnt_q == $past(cnt_q) - 16'h0001)
		else $error("down step wrong");

	chk_oneshot_stop: assert property (@(posedge clock) disable iff (reset)
		step && !ctrl.preset && !run_start && ctrl.single_pass_select && is_down
		&& at_zero |=> !busy_q)
		else $error("one-shot down did not stop");

	chk_oneshot_up_stop: assert property (@(posedge clock) disable iff (reset)
		step && !ctrl.preset && !run_start && ctrl.single_pass_select && !is_down
		&& !is_updown && up_q && at_limit |=> !busy_q && cnt_q == 16'h0000)
		else $error("one-shot up did not stop");

	chk_updown_turn: assert property (@(posedge clock) disable iff (reset)
		step && !ctrl.preset && is_updown && up_q && at_limit && !at_zero
		|=> !up_q)
		else $error("up/down did not turn");

	chk_updown_stop: assert property (@(posedge clock) disable iff (reset)
		step && !ctrl.preset && !run_start && ctrl.single_pass_select && is_updown
		&& !up_q && cnt_q == 16'h0001 |=> !busy_q && cnt_q == 16'h0000)
		else $error("one-shot up/down did not stop");

	chk_dir_status: assert property (@(posedge clock) disable iff (reset)
		ctrl.preset && is_down |=> !status.count_up_status)
		else $error("direction status wrong");

	chk_dir_up: assert property (@(posedge clock) disable iff (reset)
		ctrl.preset && !is_down |=> status.count_up_status)
		else $error("up direction status wrong");

	chk_pend_flag: assert property (@(posedge clock) disable iff (reset)
		limit_write |=> status.limit_update_pending)
		else $error("limit pending flag missing");

	chk_limit_store: assert property (@(posedge clock) disable iff (reset)
		limit_write |=> lim_q == $past(max_count_limit))
		else $error("limit not stored");

	chk_capture_copy: assert property (@(posedge clock) disable iff (reset)
		1'b1 |=> capture_mode == $past(compare_or_capture_select))
		else $error("capture mode not copied");

	chk_ext_dummy: assert property (@(posedge clock) disable iff (reset)
		is_ext && !dummy_done |-> !step)
		else $error("dummy edge counted");

	chk_ext_edge: assert property (@(posedge clock) disable iff (reset)
		is_ext && step |-> ext_edge)
		else $error("external step without edge");
endmodule // pwmtc_counter
`default_nettype wire

// ### test/pwmtc_counter_bench.sv
// Self-checking bench for the PWM timer counter block
`timescale 1ns/100ps
`default_nettype none
module pwmtc_counter_bench;
	logic clock;
	logic reset;
	pwmtc_pkg::pwmtc_ctrl_t ctrl;
	logic [15:0] limit;
	logic limit_write;
	logic count_tick;
	logic ext_in;
	logic [1:0] ccs;
	logic [1:0] fset;
	logic [1:0] fclr;
	logic [15:0] counter_value;
	pwmtc_pkg::pwmtc_stat_t status;
	logic [1:0] capture_mode;
	logic [1:0] flags;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	pwmtc_counter #(.NUM_CC(2)) dut_u (.clock(clock), .reset(reset), .ctrl(ctrl),
		.max_count_limit(limit), .limit_write(limit_write), .count_tick(count_tick),
		.external_count_input(ext_in), .compare_or_capture_select(ccs),
		.irq_flag_set(fset), .irq_flag_clear(fclr), .counter_value(counter_value),
		.status(status), .capture_mode(capture_mode), .irq_flag_register(flags));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			summarize();
		end
	end
	task automatic summarize();
		if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		total_checks++;
		if (exp !== got) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Load limit, preset, then raise run
	task automatic start(logic [1:0] dir, logic one, logic [2:0] src, logic [15:0] lim);
		@(negedge clock);
		ctrl = '{1'b1, 1'b0, 1'b0, dir, one, src};
		limit = lim;
		limit_write = 1'b1;
		@(negedge clock);
		limit_write = 1'b0;
		chk("pending", 16'h0001, 16'(status.limit_update_pending));
		ctrl.preset = 1'b1;
		@(negedge clock);
		ctrl.preset = 1'b0;
		ctrl.run = 1'b1;
		repeat (2) @(negedge clock);
	endtask
	// One count clock, then compare the count
	task automatic step(logic [15:0] exp);
		count_tick = 1'b1;
		@(negedge clock);
		count_tick = 1'b0;
		@(negedge clock);
		chk("counter_value", exp, counter_value);
	endtask
	task automatic stop_run();
		ctrl.run = 1'b0;
		repeat (2) @(negedge clock);
	endtask
	task automatic repeat_up();
		start(pwmtc_pkg::DIR_UP, 1'b0, pwmtc_pkg::SRC_INTERNAL, 16'h0003);
		chk("preset value", 16'h0000, counter_value);
		chk("busy", 16'h0001, 16'(status.counter_running_status));
		chk("up status", 16'h0001, 16'(status.count_up_status));
		step(16'h0001);
		step(16'h0002);
		step(16'h0003);
		step(16'h0000);
		step(16'h0001);
		ctrl.channel_enable_bit = 1'b0;
		step(16'h0001);
		ctrl.channel_enable_bit = 1'b1;
		step(16'h0002);
		limit = 16'h0001;
		limit_write = 1'b1;
		@(negedge clock);
		limit_write = 1'b0;
		step(16'h0000);
		step(16'h0001);
		stop_run();
		step(16'h0001);
	endtask
	task automatic one_shot_up();
		start(pwmtc_pkg::DIR_UP, 1'b1, pwmtc_pkg::SRC_INTERNAL, 16'h0002);
		step(16'h0001);
		step(16'h0002);
		step(16'h0000);
		step(16'h0000);
		chk("busy", 16'h0000, 16'(status.counter_running_status));
		stop_run();
	endtask
	task automatic one_shot_down();
		start(pwmtc_pkg::DIR_DOWN, 1'b1, pwmtc_pkg::SRC_INTERNAL, 16'h0002);
		chk("preset value", 16'h0002, counter_value);
		chk("up status", 16'h0000, 16'(status.count_up_status));
		step(16'h0001);
		step(16'h0000);
		step(16'h0002);
		step(16'h0002);
		stop_run();
	endtask
	task automatic one_shot_updown();
		start(pwmtc_pkg::DIR_UPDOWN, 1'b1, pwmtc_pkg::SRC_INTERNAL, 16'h0002);
		step(16'h0001);
		step(16'h0002);
		step(16'h0001);
		step(16'h0000);
		step(16'h0000);
		stop_run();
	endtask
	// Two dummy edges, then the third active edge counts
	task automatic external(logic [2:0] src, logic idle);
		ext_in = idle;
		start(pwmtc_pkg::DIR_UP, 1'b0, src, 16'h00FF);
		repeat (3) begin
			ext_in = ~idle;
			repeat (2) @(negedge clock);
			ext_in = idle;
			repeat (2) @(negedge clock);
		end
		chk("event count", 16'h0001, counter_value);
		stop_run();
	endtask
	task automatic flags_modes();
		ccs = 2'h2;
		fset = 2'h3;
		@(negedge clock);
		fset = 2'h0;
		fclr = 2'h1;
		@(negedge clock);
		fclr = 2'h0;
		@(negedge clock);
		chk("capture_mode", 16'h0002, 16'(capture_mode));
		chk("flags", 16'h0002, 16'(flags));
		fset = 2'h1;
		fclr = 2'h1;
		@(negedge clock);
		fset = 2'h0;
		fclr = 2'h0;
		chk("flags", 16'h0003, 16'(flags));
	endtask
	initial begin
		ctrl = '0;
		limit = 16'h0000;
		limit_write = 1'b0;
		count_tick = 1'b0;
		ext_in = 1'b0;
		ccs = 2'h0;
		fset = 2'h0;
		fclr = 2'h0;
		reset = 1'b1;
		repeat (6) @(negedge clock);
		reset = 1'b0;
		repeat_up();
		one_shot_up();
		one_shot_down();
		one_shot_updown();
		external(pwmtc_pkg::SRC_EXT, 1'b0);
		external(pwmtc_pkg::SRC_EXT_INV, 1'b1);
		flags_modes();
		summarize();
	end
endmodule // pwmtc_counter_bench
`default_nettype wire
